//--- hdl/acl_ip_match_regs.vh
/*
  Constants for the indirect access path to the per-port access control list
  IP match bytes. Assumes a simple byte-wide register port from the switch core.
*/
// Contract
// - Table select 010 routes to access_control_list
// - Control bits 3:0 pick port 1 to 5
// - Offset register 0x6F gives byte offset
// - Data register 0xA0 moves addressed byte
// - Offsets 3,4,5 hold IP bits 23:0
// - Offset 2 holds IP bits 31:24
`ifndef ACL_IP_MATCH_REGS_VH
`define ACL_IP_MATCH_REGS_VH
`define AIM_ADDR_CTRL 8'h6e
`define AIM_ADDR_OFFSET 8'h6f
`define AIM_ADDR_DATA 8'ha0
`define AIM_TABLE_MSB 7
`define AIM_TABLE_LSB 5
`define AIM_TABLE_ACL 3'h2
`define AIM_PORT_MSB 3
`define AIM_PORT_LSB 0
`define AIM_PORT_MIN 4'h1
`define AIM_PORT_MAX 4'h5
`define AIM_OFS_BYTE3 8'h02
`define AIM_OFS_BYTE2 8'h03
`define AIM_OFS_BYTE1 8'h04
`define AIM_OFS_BYTE0 8'h05
`define AIM_RESET_BYTE 8'h00
`define AIM_RESET_REG 8'h00
`endif

//--- hdl/aim_port_entry.v
/*
  One port's IP match bytes: four byte registers selected by offset.
  Assumes write strobe is a single-cycle pulse qualified by the parent.
*/
`timescale 1ns/1ns
`include "acl_ip_match_regs.vh"
module aim_port_entry (
  input wire clk,
  input wire rst,
  input wire sel,
  input wire wrEn,
  input wire [7:0] offset,
  input wire [7:0] wrData,
  output reg [7:0] rdData,
  output wire hit,
  output wire [31:0] ipMatchValue
);
  reg [7:0] ipByte3;
  reg [7:0] ipByte2;
  reg [7:0] ipByte1;
  reg [7:0] ipByte0;

  // Offset decode of the four IP bytes
  assign hit = (offset == `AIM_OFS_BYTE3) || (offset == `AIM_OFS_BYTE2) ||
               (offset == `AIM_OFS_BYTE1) || (offset == `AIM_OFS_BYTE0);
  assign ipMatchValue = {ipByte3, ipByte2, ipByte1, ipByte0};

  // Byte storage, cleared on reset
  always @(posedge clk) begin
    if (rst) begin
      ipByte3 <= `AIM_RESET_BYTE;
      ipByte2 <= `AIM_RESET_BYTE;
      ipByte1 <= `AIM_RESET_BYTE;
      ipByte0 <= `AIM_RESET_BYTE;
    end else if (sel && wrEn) begin
      case (offset)
        `AIM_OFS_BYTE3: ipByte3 <= wrData;
        `AIM_OFS_BYTE2: ipByte2 <= wrData;
        `AIM_OFS_BYTE1: ipByte1 <= wrData;
        `AIM_OFS_BYTE0: ipByte0 <= wrData;
        default: ;
      endcase
    end
  end

  // Read mux of the addressed byte
  always @* begin
    case (offset)
      `AIM_OFS_BYTE3: rdData = ipByte3;
      `AIM_OFS_BYTE2: rdData = ipByte2;
      `AIM_OFS_BYTE1: rdData = ipByte1;
      `AIM_OFS_BYTE0: rdData = ipByte0;
      default: rdData = 8'h00;
    endcase
  end
endmodule // aim_port_entry

//--- hdl/aim_acl_ip_match.v
/*
  Indirect register bank for the per-port IP match field of the access control
  list. Assumes a synchronous byte register port: regWr/regRd one-cycle
  strobes with regAddr, read data registered one cycle after regRd.
*/
`timescale 1ns/1ns
`include "acl_ip_match_regs.vh"
module aim_acl_ip_match (
  input wire clk,
  input wire rst,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  output reg [7:0] regRdData,
  output reg regRdValid,
  output wire [159:0] ipMatchValue
);
  // Port numbers of the five entries, at the width of the port field
  localparam [3:0] PORT_1 = 4'h1;
  localparam [3:0] PORT_2 = 4'h2;
  localparam [3:0] PORT_3 = 4'h3;
  localparam [3:0] PORT_4 = 4'h4;
  localparam [3:0] PORT_5 = 4'h5;

  // Indirect select and offset registers
  reg [7:0] indCtrl;
  reg [7:0] indOffset;
  // Decoded view of the select register
  wire tableAcl;
  wire [3:0] portNum;
  wire portValid;
  wire entryOpen;
  // Register port address decode
  wire addrCtrl;
  wire addrOffset;
  wire addrData;
  wire ctrlWr;
  wire offsetWr;
  wire dataWr;
  // One select line per port entry
  wire selPort1;
  wire selPort2;
  wire selPort3;
  wire selPort4;
  wire selPort5;
  // Addressed byte of each port entry
  wire [7:0] rdPort1;
  wire [7:0] rdPort2;
  wire [7:0] rdPort3;
  wire [7:0] rdPort4;
  wire [7:0] rdPort5;
  // Offset hit of each port entry
  wire hitPort1;
  wire hitPort2;
  wire hitPort3;
  wire hitPort4;
  wire hitPort5;
  // Read path
  reg [7:0] aclByte;
  reg [7:0] next_rdData;

  // Register port address decode
  assign addrCtrl = (regAddr == `AIM_ADDR_CTRL);
  assign addrOffset = (regAddr == `AIM_ADDR_OFFSET);
  assign addrData = (regAddr == `AIM_ADDR_DATA);
  assign ctrlWr = regWr && addrCtrl;
  assign offsetWr = regWr && addrOffset;

  // Table select and port number decode
  assign tableAcl = indCtrl[`AIM_TABLE_MSB:`AIM_TABLE_LSB] == `AIM_TABLE_ACL;
  assign portNum = indCtrl[`AIM_PORT_MSB:`AIM_PORT_LSB];
  assign portValid = (portNum >= `AIM_PORT_MIN) && (portNum <= `AIM_PORT_MAX);
  // The data register reaches an entry only for the list table and ports 1..5
  assign entryOpen = tableAcl && portValid;
  assign dataWr = regWr && addrData && entryOpen;

  // Port number to entry select; ports 0 and 6..15 select no entry
  assign selPort1 = (portNum == PORT_1);
  assign selPort2 = (portNum == PORT_2);
  assign selPort3 = (portNum == PORT_3);
  assign selPort4 = (portNum == PORT_4);
  assign selPort5 = (portNum == PORT_5);

  // Control and offset registers written directly; control bit 4 is kept
  // and read back but selects nothing
  always @(posedge clk) begin
    if (rst) begin
      indCtrl <= `AIM_RESET_REG;
      indOffset <= `AIM_RESET_REG;
    end else begin
      if (ctrlWr) begin
        indCtrl <= regWrData;
      end
      if (offsetWr) begin
        indOffset <= regWrData;
      end
    end
  end

  // All entries share offset and write data; only the select line decides
  // which entry a data write lands in
  // Port 1 entry, match word in bits 31:0
  aim_port_entry uEntry1 (
    .clk(clk),
    .rst(rst),
    .sel(selPort1),
    .wrEn(dataWr),
    .offset(indOffset),
    .wrData(regWrData),
    .rdData(rdPort1),
    .hit(hitPort1),
    .ipMatchValue(ipMatchValue[31:0])
  );

  // Port 2 entry, match word in bits 63:32
  aim_port_entry uEntry2 (
    .clk(clk),
    .rst(rst),
    .sel(selPort2),
    .wrEn(dataWr),
    .offset(indOffset),
    .wrData(regWrData),
    .rdData(rdPort2),
    .hit(hitPort2),
    .ipMatchValue(ipMatchValue[63:32])
  );

  // Port 3 entry, match word in bits 95:64
  aim_port_entry uEntry3 (
    .clk(clk),
    .rst(rst),
    .sel(selPort3),
    .wrEn(dataWr),
    .offset(indOffset),
    .wrData(regWrData),
    .rdData(rdPort3),
    .hit(hitPort3),
    .ipMatchValue(ipMatchValue[95:64])
  );

  // Port 4 entry, match word in bits 127:96
  aim_port_entry uEntry4 (
    .clk(clk),
    .rst(rst),
    .sel(selPort4),
    .wrEn(dataWr),
    .offset(indOffset),
    .wrData(regWrData),
    .rdData(rdPort4),
    .hit(hitPort4),
    .ipMatchValue(ipMatchValue[127:96])
  );

  // Port 5 entry, match word in bits 159:128
  aim_port_entry uEntry5 (
    .clk(clk),
    .rst(rst),
    .sel(selPort5),
    .wrEn(dataWr),
    .offset(indOffset),
    .wrData(regWrData),
    .rdData(rdPort5),
    .hit(hitPort5),
    .ipMatchValue(ipMatchValue[159:128])
  );

  // Select the addressed list byte for the data register; a closed path,
  // an invalid port or an unmapped offset reads as zero
  always @* begin
    aclByte = `AIM_RESET_BYTE;
    if (entryOpen) begin
      case (portNum)
        PORT_1: begin
          if (hitPort1) begin
            aclByte = rdPort1;
          end
        end
        PORT_2: begin
          if (hitPort2) begin
            aclByte = rdPort2;
          end
        end
        PORT_3: begin
          if (hitPort3) begin
            aclByte = rdPort3;
          end
        end
        PORT_4: begin
          if (hitPort4) begin
            aclByte = rdPort4;
          end
        end
        PORT_5: begin
          if (hitPort5) begin
            aclByte = rdPort5;
          end
        end
        default: aclByte = `AIM_RESET_BYTE;
      endcase
    end
  end

  // Read-back mux for the register port
  always @* begin
    case (regAddr)
      `AIM_ADDR_CTRL: next_rdData = indCtrl;
      `AIM_ADDR_OFFSET: next_rdData = indOffset;
      `AIM_ADDR_DATA: next_rdData = aclByte;
      default: next_rdData = `AIM_RESET_REG;
    endcase
  end

  // Registered read answer; data is captured only on a read strobe, so it
  // stands until the next read
  always @(posedge clk) begin
    if (rst) begin
      regRdData <= `AIM_RESET_REG;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRd;
      if (regRd) begin
        regRdData <= next_rdData;
      end
    end
  end
endmodule // aim_acl_ip_match

//--- tb/aim_checker.sv
/* Port checker for aim_acl_ip_match.
   Assumes a bind from the bench top. */
`timescale 1ns/1ns
module aim_checker (
  input wire clk,
  input wire rst,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire [7:0] regRdData,
  input wire regRdValid,
  input wire [159:0] ipMatchValue
);
  reg [7:0] ctl;
  reg [7:0] ofs;
  wire dw = regWr && regAddr == 8'ha0;
  wire [7:0] lo = ipMatchValue[7:0];
  // Shadow of the select and offset registers
  always @(posedge clk) begin
    if (rst) begin
      ctl <= 8'h00;
      ofs <= 8'h00;
    end else if (regWr) begin
      if (regAddr == 8'h6e) ctl <= regWrData;
      if (regAddr == 8'h6f) ofs <= regWrData;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  rd_valid_a: assert property (regRd |=> regRdValid) else $error("no read valid");
  reset_zero_a: assert property ($fell(rst) |-> ipMatchValue == 160'h0)
    else $error("bytes not cleared");
  bad_table_a: assert property (dw && ctl[7:5] != 3'h2 |=> $stable(ipMatchValue))
    else $error("write off table");
  mid_byte_a: assert property (dw && ctl == 8'h41 && ofs == 8'h03
    |=> ipMatchValue[23:16] == $past(regWrData)) else $error("byte 3 wrong");
  top_byte_a: assert property (dw && ctl == 8'h42 && ofs == 8'h02
    |=> ipMatchValue[63:56] == $past(regWrData)) else $error("port 2 top wrong");
  read_back_a: assert property (regRd && regAddr == 8'ha0 && ctl == 8'h41 && ofs == 8'h05
    |=> regRdData == $past(lo)) else $error("read back wrong");
  bad_port_a: assert property (dw && (ctl[3:0] == 4'h0 || ctl[3:0] > 4'h5)
    |=> $stable(ipMatchValue)) else $error("write off port");
  bad_offset_a: assert property (dw && (ofs < 8'h02 || ofs > 8'h05)
    |=> $stable(ipMatchValue)) else $error("write off offset");
  rd_pulse_a: assert property (!regRd |=> !regRdValid) else $error("read valid stuck");
endmodule // aim_checker

//--- tb/aim_acl_ip_match_bench.sv
/* Bench for aim_acl_ip_match.
   Assumes the checker is compiled first. */
`timescale 1ns/1ns
module aim_acl_ip_match_bench;
  reg clk = 0, rst = 1, regWr = 0, regRd = 0;
  reg [7:0] regAddr = 8'h00, regWrData = 8'h00;
  reg [159:0] want = 160'h0;
  wire [7:0] regRdData;
  wire regRdValid;
  wire [159:0] ipMatchValue;
  integer errTotal = 0, comparisons = 0, cyc = 0;
  aim_acl_ip_match DUT (.clk(clk), .rst(rst), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .ipMatchValue(ipMatchValue));
  initial forever #5 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      errTotal = errTotal + 1;
      wrapUp;
    end
  end
  task check(input [159:0] got, input [159:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        errTotal = errTotal + 1;
        $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task acc(input w, input [7:0] a, input [7:0] d);
    begin
      @(negedge clk);
      regWr = w;
      regRd = !w;
      regAddr = a;
      regWrData = d;
      @(negedge clk);
      regWr = 0;
      regRd = 0;
    end
  endtask
  task rdReg(input [7:0] a, input [7:0] exp);
    begin
      acc(0, a, 8'h00);
      check({regRdValid, regRdData}, {1'b1, exp});
      @(negedge clk);
      check({regRdValid, regRdData}, {1'b0, exp});
    end
  endtask
  task rd(input [7:0] exp);
    begin
      rdReg(8'ha0, exp);
    end
  endtask
  task sel(input [7:0] c, input [7:0] o);
    begin
      acc(1, 8'h6e, c);
      acc(1, 8'h6f, o);
    end
  endtask
  task testReset;
    begin
      sel(8'h41, 8'h02);
      rd(8'h00);
      check(ipMatchValue, want);
    end
  endtask
  task testWalk;
    integer p, o;
    begin
      for (p = 1; p < 6; p = p + 1) for (o = 2; o < 6; o = o + 1) begin
        sel({4'h4, p[3:0]}, o[7:0]);
        acc(1, 8'ha0, {p[3:0], o[3:0]});
        want[(p - 1) * 32 + (5 - o) * 8 +: 8] = {p[3:0], o[3:0]};
      end
      check(ipMatchValue, want);
      sel(8'h43, 8'h04);
      rd(8'h34);
      sel(8'h41, 8'h05);
      rd(8'h15);
      rdReg(8'h6f, 8'h05);
      sel(8'h45, 8'h02);
      rd(8'h52);
    end
  endtask
  task testRefuse;
    begin
      sel(8'h61, 8'h03);
      acc(1, 8'ha0, 8'hff);
      rd(8'h00);
      sel(8'h46, 8'h03);
      acc(1, 8'ha0, 8'hff);
      rd(8'h00);
      sel(8'h40, 8'h03);
      acc(1, 8'ha0, 8'hff);
      sel(8'h41, 8'h06);
      acc(1, 8'ha0, 8'hff);
      rd(8'h00);
      acc(1, 8'h70, 8'hff);
      check(ipMatchValue, want);
      rdReg(8'h70, 8'h00);
    end
  endtask
  task testMidReset;
    begin
      rdReg(8'h6e, 8'h41);
      @(negedge clk);
      rst = 1;
      repeat (2) @(negedge clk);
      rst = 0;
      want = 160'h0;
      check(ipMatchValue, want);
      check({regRdValid, regRdData}, 9'h000);
      sel(8'h41, 8'h02);
      rd(8'h00);
      rdReg(8'h6f, 8'h02);
    end
  endtask
  task wrapUp;
    begin
      if (errTotal == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    testReset;
    testWalk;
    testRefuse;
    testMidReset;
    wrapUp;
  end
endmodule // aim_acl_ip_match_bench
bind aim_acl_ip_match aim_checker chk (.clk(clk), .rst(rst), .regWr(regWr), .regRd(regRd),
  .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
  .ipMatchValue(ipMatchValue));
